// File: hdl/assp_pkg.sv
// constants for the angle short stroke path
package assp_pkg;
    localparam int unsigned ANG_W = 12;
    localparam int unsigned GAIN_W = 13;
    localparam int unsigned GAIN_FRAC = 8;
    localparam int unsigned CLAMP_W = 8;
    // register byte offsets
    localparam logic [7:0] OFS_PREGAIN = 8'h00;
    localparam logic [7:0] OFS_GAIN = 8'h04;
    localparam logic [7:0] OFS_INPUT = 8'h08;
    localparam logic [7:0] OFS_POST = 8'h0c;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_MASK = 8'h18;
    localparam logic [7:0] OFS_ANGLE = 8'h1c;
    // field positions
    localparam int unsigned SS_BIT = 25;
    localparam int unsigned CE_BIT = 25;
    localparam int unsigned WRAP_BIT = 24;
    localparam int unsigned HI_LSB = 16;
    localparam int unsigned FIELD_HI_LSB = 12;
    localparam int unsigned POL_BIT = 0;
    localparam int unsigned CLAMP_SHIFT = ANG_W - CLAMP_W;
    // status bits
    localparam int unsigned ST_OOR = 0;
    localparam int unsigned ST_BACK = 1;
    localparam int unsigned ST_SAMPLE = 2;
    localparam int unsigned ST_W = 3;
    localparam logic [11:0] ANG_MAX = 12'hfff;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
endpackage : assp_pkg

// File: hdl/assp_top.sv
// angle post-processing: offsets, bound check, gain, clamp/roll-over, polarity
//
// Overview of operation
// - pre-gain zero offset subtracted from measured angle before gain.
// - polarity one replaces final angle by 360 degrees minus angle.
// - short stroke compares pre-gain corrected angle with input bounds.
// - angle outside input bounds tristates output, even with clamping.
// - digital gain multiply, range reaching 11.25 degrees to full scale.
// - both limit controls clear, gained angle wraps modulo 360 degrees.
// - post-gain trim added after gain, before clamp and roll-over.
// - clamp 0, wrap 0: plain modulo 360 wrap.
// - clamp 0, wrap 1: wrap between lower and upper output limits.
// - clamp 1, wrap 0: saturate at first limit reached and hold.
// - clamp 1, wrap 1: wrap modulo 360 then limit to output limits.
// - gain field unsigned 5.8, applied gain one plus field, short stroke only.
// - short stroke select enables gain and bound checks; else neither acts.
// - pre-gain offset is 12 bits covering one full turn.
// - upper input bound of all ones disables upper bound check.
`timescale 1ns/1ps
`default_nettype none
module assp_top (
    input wire logic pclk, // apb clock, 125 MHz
    input wire logic presetn, // async reset, active low
    input wire logic clk_en, // freezes all state while low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic ang_valid, // averaged angle sample strobe
    input wire logic [11:0] ang_in, // averaged angle, full turn = 4096
    output logic out_valid, // one-cycle pulse with new result
    output logic [11:0] out_angle, // processed angle to output stage
    output logic out_tristate, // diagnostic high-impedance request
    output logic irq // level interrupt
);
    // =========================================================
    // register file
    // =========================================================
    logic [11:0] pregain_q, pregain_d;
    logic [12:0] gain_q, gain_d;
    logic ss_q, ss_d;
    logic [11:0] min_in_q, min_in_d, max_in_q, max_in_d;
    logic ce_q, ce_d, wrap_q, wrap_d;
    logic [11:0] post_gain_trim_q, post_gain_trim_d;
    logic [7:0] hi_clamp_q, hi_clamp_d, lo_clamp_q, lo_clamp_d;
    logic pol_q, pol_d;
    logic [2:0] status_q, status_d, mask_q, mask_d;
    logic [31:0] prdata_d;
    logic slverr_d;
    logic [2:0] events;
    logic wait_q, wait_d;

    // writes land only at the edge that completes the transfer
    wire logic wr = psel && penable && pwrite && wait_q;
    wire logic rd = psel && penable && !pwrite;

    function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
        hit = (a[31:8] == 24'h00_0000) && (a[7:0] == ofs);
    endfunction : hit

    function automatic logic mapped(input logic [31:0] a);
        mapped = hit(a, assp_pkg::OFS_PREGAIN) || hit(a, assp_pkg::OFS_GAIN)
            || hit(a, assp_pkg::OFS_INPUT) || hit(a, assp_pkg::OFS_POST)
            || hit(a, assp_pkg::OFS_CTRL) || hit(a, assp_pkg::OFS_STATUS)
            || hit(a, assp_pkg::OFS_MASK) || hit(a, assp_pkg::OFS_ANGLE);
    endfunction : mapped

    always_comb
    begin
        pregain_d = pregain_q;
        gain_d = gain_q;
        ss_d = ss_q;
        min_in_d = min_in_q;
        max_in_d = max_in_q;
        ce_d = ce_q;
        wrap_d = wrap_q;
        post_gain_trim_d = post_gain_trim_q;
        hi_clamp_d = hi_clamp_q;
        lo_clamp_d = lo_clamp_q;
        pol_d = pol_q;
        mask_d = mask_q;
        status_d = status_q;
        prdata_d = assp_pkg::RST_ZERO;
        // error registered in the first access cycle so it stands with pready only
        slverr_d = psel && penable && !wait_q && !mapped(paddr);
        if (wr)
        begin
            if (hit(paddr, assp_pkg::OFS_PREGAIN))
                pregain_d = pwdata[assp_pkg::FIELD_HI_LSB +: assp_pkg::ANG_W];
            if (hit(paddr, assp_pkg::OFS_GAIN))
            begin
                ss_d = pwdata[assp_pkg::SS_BIT];
                gain_d = pwdata[assp_pkg::GAIN_W-1:0];
            end
            if (hit(paddr, assp_pkg::OFS_INPUT))
            begin
                ce_d = pwdata[assp_pkg::CE_BIT];
                wrap_d = pwdata[assp_pkg::WRAP_BIT];
                max_in_d = pwdata[assp_pkg::FIELD_HI_LSB +: assp_pkg::ANG_W];
                min_in_d = pwdata[assp_pkg::ANG_W-1:0];
            end
            if (hit(paddr, assp_pkg::OFS_POST))
            begin
                post_gain_trim_d = pwdata[assp_pkg::HI_LSB +: assp_pkg::ANG_W];
                hi_clamp_d = pwdata[assp_pkg::CLAMP_W +: assp_pkg::CLAMP_W];
                lo_clamp_d = pwdata[assp_pkg::CLAMP_W-1:0];
            end
            if (hit(paddr, assp_pkg::OFS_CTRL))
                pol_d = pwdata[assp_pkg::POL_BIT];
            if (hit(paddr, assp_pkg::OFS_MASK))
                mask_d = pwdata[assp_pkg::ST_W-1:0];
            if (hit(paddr, assp_pkg::OFS_STATUS))
                status_d = status_q & ~pwdata[assp_pkg::ST_W-1:0];
        end
        // set wins over a simultaneous write-one clear
        status_d = status_d | events;
        if (rd)
        begin
            unique case (1'b1)
                hit(paddr, assp_pkg::OFS_PREGAIN): prdata_d = {8'h00, pregain_q, 12'h000};
                hit(paddr, assp_pkg::OFS_GAIN): prdata_d = {6'h00, ss_q, 12'h000, gain_q};
                hit(paddr, assp_pkg::OFS_INPUT): prdata_d = {6'h00, ce_q, wrap_q, max_in_q, min_in_q};
                hit(paddr, assp_pkg::OFS_POST): prdata_d = {4'h0, post_gain_trim_q, hi_clamp_q, lo_clamp_q};
                hit(paddr, assp_pkg::OFS_CTRL): prdata_d = {31'h0000_0000, pol_q};
                hit(paddr, assp_pkg::OFS_STATUS): prdata_d = {29'h0000_0000, status_q};
                hit(paddr, assp_pkg::OFS_MASK): prdata_d = {29'h0000_0000, mask_q};
                hit(paddr, assp_pkg::OFS_ANGLE): prdata_d = {19'h0_0000, out_tristate, out_angle};
                default: prdata_d = assp_pkg::RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pregain_q <= 12'h000;
            gain_q <= 13'h0000;
            ss_q <= 1'b0;
            min_in_q <= 12'h000;
            max_in_q <= 12'h000;
            ce_q <= 1'b0;
            wrap_q <= 1'b0;
            post_gain_trim_q <= 12'h000;
            hi_clamp_q <= 8'h00;
            lo_clamp_q <= 8'h00;
            pol_q <= 1'b0;
            status_q <= 3'h0;
            mask_q <= 3'h0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else if (clk_en)
        begin
            pregain_q <= pregain_d;
            gain_q <= gain_d;
            ss_q <= ss_d;
            min_in_q <= min_in_d;
            max_in_q <= max_in_d;
            ce_q <= ce_d;
            wrap_q <= wrap_d;
            post_gain_trim_q <= post_gain_trim_d;
            hi_clamp_q <= hi_clamp_d;
            lo_clamp_q <= lo_clamp_d;
            pol_q <= pol_d;
            status_q <= status_d;
            mask_q <= mask_d;
            prdata <= prdata_d;
            pslverr <= slverr_d;
        end
    end

    // one wait state: answer from registered read data
    always_comb
    begin
        wait_d = psel && penable && !wait_q;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wait_q <= 1'b0;
        else if (clk_en)
            wait_q <= wait_d;
    end
    assign pready = wait_q && clk_en;

    assign irq = |(status_q & mask_q);

    // =========================================================
    // angle path, single pass per sample
    // =========================================================
    logic [11:0] ang_q, ang_d;
    logic tri_q, tri_d;
    logic vld_q, vld_d;
    logic held_q, held_d;
    logic [11:0] held_ang_q, held_ang_d;
    logic [11:0] pre;
    logic oor;
    logic [13:0] gain_full;
    logic [25:0] prod;
    logic [11:0] gained;
    logic [11:0] trimmed;
    logic [11:0] lo_lim, hi_lim;
    logic [12:0] span;
    logic [11:0] limited;
    logic [11:0] lin;

    always_comb
    begin
        pre = ang_in - pregain_q;
        // bound check in short stroke only
        oor = ss_q && ((pre < min_in_q) || ((max_in_q != assp_pkg::ANG_MAX) && (pre > max_in_q)));
        // gain is one plus 5.8 field
        gain_full = ss_q ? ({1'b0, gain_q} + 14'h0100) : 14'h0100;
        prod = {14'h0000, pre} * {12'h000, gain_full};
        // keep low bits, modulo one turn
        gained = prod[assp_pkg::GAIN_FRAC +: assp_pkg::ANG_W];
        trimmed = gained + post_gain_trim_q;
        lo_lim = {lo_clamp_q, 4'h0};
        hi_lim = {hi_clamp_q, 4'h0};
        lin = prod[19:8] | {12{|prod[25:20]}};
        span = {1'b0, hi_lim} - {1'b0, lo_lim} + 13'h0001;
        limited = trimmed;
        // a sample in any other mode drops a stale hold
        held_d = 1'b0;
        held_ang_d = held_ang_q;
        unique case ({ce_q, wrap_q})
            2'b00: limited = trimmed;
            2'b01:
            begin
                if (span[12] || span == 13'h0000)
                    limited = lo_lim;
                else if (trimmed < lo_lim)
                    // below the low limit counts as past the turn boundary
                    limited = 12'((({1'b0, trimmed} + 13'h1000 - {1'b0, lo_lim}) % span) + {1'b0, lo_lim});
                else
                    limited = 12'((({1'b0, trimmed} - {1'b0, lo_lim}) % span) + {1'b0, lo_lim});
            end
            // saturate at first limit met and hold until back inside
            2'b10:
            begin
                if (trimmed > hi_lim || trimmed < lo_lim || lin == 12'hfff)
                begin
                    if (!held_q)
                        held_ang_d = (lin == 12'hfff || trimmed > hi_lim) ? hi_lim : lo_lim;
                    held_d = 1'b1;
                    limited = held_d ? held_ang_d : trimmed;
                end
                else
                    held_d = 1'b0;
            end
            2'b11: limited = (trimmed > hi_lim) ? hi_lim : ((trimmed < lo_lim) ? lo_lim : trimmed);
        endcase
        if (!ang_valid)
        begin
            held_d = held_q;
            held_ang_d = held_ang_q;
        end
        ang_d = ang_q;
        tri_d = tri_q;
        vld_d = ang_valid;
        if (ang_valid)
        begin
            ang_d = pol_q ? 12'(13'h1000 - {1'b0, limited}) : limited;
            tri_d = oor;
        end
        events = {ang_valid, ang_valid && tri_q && !oor, ang_valid && oor && !tri_q};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ang_q <= 12'h000;
            tri_q <= 1'b0;
            vld_q <= 1'b0;
            held_q <= 1'b0;
            held_ang_q <= 12'h000;
        end
        else if (clk_en)
        begin
            ang_q <= ang_d;
            tri_q <= tri_d;
            vld_q <= vld_d;
            held_q <= held_d;
            held_ang_q <= held_ang_d;
        end
    end

    assign out_angle = ang_q;
    assign out_tristate = tri_q;
    assign out_valid = vld_q;
endmodule : assp_top
`default_nettype wire

// File: test/assp_props.sv
// checker for the angle path and the apb handshake
`timescale 1ns/1ps
`default_nettype none
module assp_props (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic clk_en, // run
    input wire logic psel, // select
    input wire logic penable, // access
    input wire logic pwrite, // direction
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic ang_valid, // sample in
    input wire logic out_valid, // result
    input wire logic [11:0] out_angle, // angle
    input wire logic out_tristate, // hiz request
    input wire logic irq // interrupt
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence acc_start;
        psel && penable && !$past(penable) && clk_en;
    endsequence
    sequence one_wait;
        !pready ##1 pready;
    endsequence
    ans_one_wait_a: assert property (acc_start |-> one_wait) else $error("apb answer not after one wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    result_next_a: assert property (ang_valid && clk_en |=> out_valid) else $error("no result after sample");
    result_cause_a: assert property (out_valid |-> $past(ang_valid)) else $error("result without sample");
    angle_hold_a: assert property (!out_valid |-> $stable(out_angle)) else $error("angle moved between samples");
    hiz_hold_a: assert property (!out_valid |-> $stable(out_tristate)) else $error("hiz moved between samples");
    irq_cause_a: assert property ($rose(irq) |-> out_valid || $past(out_valid) || $past(pready && pwrite))
        else $error("irq rose without cause");
endmodule : assp_props
bind assp_top assp_props u_props (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .ang_valid(ang_valid),
    .out_valid(out_valid), .out_angle(out_angle), .out_tristate(out_tristate), .irq(irq));
`default_nettype wire

// File: test/assp_out_stage.sv
// behavioural output stage fed by the angle path
`timescale 1ns/1ps
`default_nettype none
module assp_out_stage (
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic out_valid, // new result
    input wire logic [11:0] out_angle, // angle
    input wire logic out_tristate, // hiz request
    output logic [11:0] drive_level, // held level
    output logic drive_hiz // pin released
);
    // released until the first result, like an unpowered driver
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
        begin
            drive_level <= 12'h000;
            drive_hiz <= 1'b1;
        end
        else if (out_valid)
        begin
            drive_level <= out_angle;
            drive_hiz <= out_tristate;
        end
endmodule : assp_out_stage
`default_nettype wire

// File: test/tb_angle_short_stroke_path.sv
// self-checking bench for the angle short stroke path
`timescale 1ns/1ps
`default_nettype none
module tb_angle_short_stroke_path;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ang_valid = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic [11:0] ang_in = 12'h000, out_angle, lvl;
    logic pready, pslverr, out_valid, out_tristate, irq, hiz, er;
    logic [31:0] w_pre = 32'h0, w_gain = 32'h0, w_in = 32'h0, w_post = 32'h0, w_pol = 32'h0;
    logic [12:0] expq[$];
    logic [12:0] em;
    logic m_held = 1'b0;
    logic [11:0] m_hang = 12'h000;
    logic [11:0] ss_list [7] = '{12'h00f, 12'h010, 12'h300, 12'h301, 12'h100, 12'h2a0, 12'hfff};
    int fails = 0, checks_done = 0;
    always #4 pclk = ~pclk;
    assp_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ang_valid(ang_valid),
        .ang_in(ang_in), .out_valid(out_valid), .out_angle(out_angle), .out_tristate(out_tristate), .irq(irq));
    assp_out_stage u_stage (.pclk(pclk), .presetn(presetn), .out_valid(out_valid), .out_angle(out_angle),
        .out_tristate(out_tristate), .drive_level(lvl), .drive_hiz(hiz));
    // ==========
    // helpers
    task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            fails++;
            $display("wrong value %s expected %h seen %h", s, x, g);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up
    // idle cycle after release so back-to-back calls never reassign in one step
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (n >= 20)
            fails++;
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0, rd, er);
        chk(s, x, rd);
    endtask : rdc
    task automatic cfg;
        apb(1'b1, assp_pkg::OFS_PREGAIN, w_pre, rd, er);
        apb(1'b1, assp_pkg::OFS_GAIN, w_gain, rd, er);
        apb(1'b1, assp_pkg::OFS_INPUT, w_in, rd, er);
        apb(1'b1, assp_pkg::OFS_POST, w_post, rd, er);
        apb(1'b1, assp_pkg::OFS_CTRL, w_pol, rd, er);
    endtask : cfg
    function automatic logic [12:0] model(input logic [11:0] a);
        logic [11:0] x, y, lo, hi;
        logic [25:0] p;
        logic t;
        logic ovf;
        int u, sp;
        x = a - w_pre[23:12];
        p = {14'h0, x} * (26'd256 + {13'h0, w_gain[12:0]});
        y = w_gain[25] ? p[19:8] : x;
        ovf = (w_gain[25] && p[25:20] != 6'h00) || y == 12'hfff;
        t = w_gain[25] && (x < w_in[11:0] || (w_in[23:12] != 12'hfff && x > w_in[23:12]));
        y = y + w_post[27:16];
        lo = {w_post[7:0], 4'h0};
        hi = {w_post[15:8], 4'h0};
        sp = int'(hi) - int'(lo) + 1;
        u = (y < lo) ? int'(y) + 4096 : int'(y);
        if (w_in[25:24] == 2'b01)
            y = (sp < 1) ? lo : 12'(int'(lo) + (u - int'(lo)) % sp);
        if (w_in[25:24] == 2'b10)
        begin
            if (y > hi || y < lo || ovf)
            begin
                if (!m_held)
                    m_hang = (ovf || y > hi) ? hi : lo;
                m_held = 1'b1;
                y = m_hang;
            end
            else
                m_held = 1'b0;
        end
        else
            m_held = 1'b0;
        if (w_in[25] && w_in[24])
            y = (y < lo) ? lo : ((y > hi) ? hi : y);
        if (w_pol[0])
            y = 12'h000 - y;
        return {t, y};
    endfunction : model
    task automatic send(input logic [11:0] a);
        ang_valid <= 1'b1;
        ang_in <= a;
        expq.push_back(model(a));
        @(posedge pclk);
    endtask : send
    task automatic idle;
        ang_valid <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : idle
    always @(posedge pclk)
        if (out_valid === 1'b1)
        begin
            em = expq.size() > 0 ? expq.pop_front() : 13'h1fff;
            chk("tristate", 32'(em[12]), 32'(out_tristate));
            if (em[12] === 1'b0)
                chk("angle", 32'(em[11:0]), 32'(out_angle));
        end
    // ==========
    // main sequence
    initial
    begin
        void'($urandom(27));
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdc("gain reg", assp_pkg::OFS_GAIN, 32'h0);
        apb(1'b0, 8'h20, 32'h0, rd, er);
        chk("slverr", 32'h1, 32'(er));
        $display("test registers done");
        for (int p = 0; p < 2; p++)
        begin
            w_pre = {8'h0, 12'($urandom), 12'h0};
            w_post = $urandom & 32'h0fff_ffff;
            w_pol = p;
            cfg();
            repeat (8) send(12'($urandom));
            idle();
        end
        $display("test plain path done");
        w_pre = 32'h0;
        w_post = 32'h0;
        w_pol = 32'h0;
        w_gain = 32'h0200_055a;
        for (int m = 0; m < 2; m++)
        begin
            w_in = m ? 32'h00ff_f010 : 32'h0030_0010;
            cfg();
            foreach (ss_list[i]) send(ss_list[i]);
            idle();
        end
        $display("test short stroke done");
        w_gain = 32'h0200_0200;
        w_post = 32'h000e_e00a;
        w_pol = 32'h1;
        for (int c = 1; c < 4; c++)
        begin
            w_in = {6'h00, 2'(c), 24'hfff000};
            cfg();
            foreach (ss_list[i]) send(ss_list[i]);
            idle();
        end
        $display("test clamp done");
        apb(1'b1, assp_pkg::OFS_STATUS, 32'h7, rd, er);
        apb(1'b1, assp_pkg::OFS_MASK, 32'h4, rd, er);
        chk("irq idle", 32'h0, 32'(irq));
        send(12'h123);
        idle();
        chk("irq set", 32'h1, 32'(irq));
        rdc("status", assp_pkg::OFS_STATUS, 32'h4);
        rdc("angle reg", assp_pkg::OFS_ANGLE, {19'h0, model(12'h123)});
        chk("stage", 32'(model(12'h123)), {19'h0, hiz, lvl});
        apb(1'b1, assp_pkg::OFS_STATUS, 32'h4, rd, er);
        chk("irq clear", 32'h0, 32'(irq));
        apb(1'b1, assp_pkg::OFS_MASK, 32'h0, rd, er);
        send(12'h050);
        idle();
        chk("irq masked", 32'h0, 32'(irq));
        chk("pending", 32'h0, 32'(expq.size()));
        $display("test interrupt done");
        wrap_up();
    end
    initial
    begin
        #100000;
        fails++;
        wrap_up();
    end
endmodule : tb_angle_short_stroke_path
`default_nettype wire
